// *** rtl/art_pkg.sv ***
// Purpose: shared constants of the auto-reload timer with toggle output
// Assumes: 32-bit APB register bus, 200 MHz pclk
// Notes:   offsets are byte addresses, one aligned word per register
package art_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_COUNT    = 8'h00;
  localparam logic [7:0] OFF_RELOAD   = 8'h04;
  localparam logic [7:0] OFF_CONTROL  = 8'h08;
  localparam logic [7:0] OFF_IRQ_REQ  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
  localparam logic [7:0] OFF_IRQ_PRIO = 8'h14;

  // ----------------------------------------------------------------
  // control register layout and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_SEL_LSB   = 0;
  localparam int         CTRL_SEL_MSB   = 2;
  localparam int         CTRL_RUN_BIT   = 3;
  localparam int         CTRL_LEVEL_BIT = 7;
  localparam logic [7:0] CTRL_FIXED     = 8'h70;
  localparam logic [7:0] CTRL_RESET     = 8'h70;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] RELOAD_RESET   = 8'h00;
  localparam logic [7:0] COUNT_TOP      = 8'hFF;
  localparam logic [1:0] PRIO_RESET     = 2'h0;
  localparam logic [15:0] IRQ_VECTOR    = 16'h0036;

  // ----------------------------------------------------------------
  // count clock selection: divide pclk by 2**code, codes 6 and 7 prohibited
  // ----------------------------------------------------------------
  localparam int         PRESCALE_BITS = 5;
  localparam logic [2:0] SEL_LAST_OK   = 3'h5;

endpackage : art_pkg

// *** rtl/art_tick_if.sv ***
// Purpose: carries the count clock selection and the count pulse
// Assumes: one pclk domain
// Notes:   timer drives the selection, prescaler drives the pulse
`timescale 1ns/1ps
`default_nettype none
interface art_tick_if;
  logic [2:0] select;
  logic       tick;
  modport timer     (output select, input tick);
  modport prescaler (input select, output tick);
endinterface : art_tick_if
`default_nettype wire

// *** rtl/art_prescaler.sv ***
// Purpose: count clock generator for the reload timer
// Assumes: selection code from the control register
// Notes:   pulse is one pclk wide for codes 1 to 5, high every cycle for code 0, registered
`timescale 1ns/1ps
`default_nettype none
module art_prescaler (
  input  wire logic  pclk,
  input  wire logic  presetn,
  art_tick_if.prescaler tick_port
);

  logic [art_pkg::PRESCALE_BITS-1:0] divider;
  logic [art_pkg::PRESCALE_BITS-1:0] next_divider;
  logic [art_pkg::PRESCALE_BITS-1:0] mask;
  logic                              tick_q;
  logic                              next_tick;

  // ----------------------------------------------------------------
  // free running divider, pulse when the selected low bits are all ones
  // ----------------------------------------------------------------
  always_comb begin
    next_divider = divider + 5'h01;
    mask         = 5'((6'h01 << tick_port.select) - 6'h01);
    if (tick_port.select > art_pkg::SEL_LAST_OK) begin
      next_tick = 1'b0;
    end else begin
      next_tick = ((divider & mask) == mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider <= '0;
      tick_q  <= 1'b0;
    end else begin
      divider <= next_divider;
      tick_q  <= next_tick;
    end
  end

  assign tick_port.tick = tick_q;

endmodule : art_prescaler
`default_nettype wire

// *** rtl/art_timer.sv ***
// Purpose: 8-bit auto-reload up timer with toggle output and APB registers
// Assumes: APB master keeps requests stable until pready
// Notes:   overflow also feeds serial channel one as baud clock
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module art_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        timer_out,
  output var  logic        baud_tick,
  output var  logic        overflow_irq,
  output var  logic [1:0]  irq_priority,
  output var  logic [15:0] irq_vector
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  timer_count;
  logic [7:0]  timer_reload;
  logic [7:0]  timer_control;
  logic        overflow_irq_request;
  logic        overflow_irq_enable;
  logic [1:0]  overflow_priority;
  logic [7:0]  next_count;
  logic [7:0]  next_reload;
  logic [7:0]  next_control;
  logic        next_request;
  logic        next_enable;
  logic [1:0]  next_priority;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_baud;
  logic        next_irq;
  logic        overflow;
  logic        wr_access;
  logic        wr_count;
  logic        wr_reload;
  logic        wr_control;
  logic        wr_request;
  logic        wr_enable;
  logic        wr_priority;
  logic        mapped;
  logic [7:0]  control_read;

  art_tick_if tick_bus ();

  art_prescaler u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_port (tick_bus.prescaler)
  );

  assign tick_bus.select = timer_control[art_pkg::CTRL_SEL_MSB:art_pkg::CTRL_SEL_LSB];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  always_comb begin
    mapped = (paddr == art_pkg::OFF_COUNT) || (paddr == art_pkg::OFF_RELOAD) ||
             (paddr == art_pkg::OFF_CONTROL) || (paddr == art_pkg::OFF_IRQ_REQ) ||
             (paddr == art_pkg::OFF_IRQ_EN) || (paddr == art_pkg::OFF_IRQ_PRIO);
    wr_access   = psel && penable && pready && pwrite;
    wr_count    = wr_access && (paddr == art_pkg::OFF_COUNT);
    wr_reload   = wr_access && (paddr == art_pkg::OFF_RELOAD);
    wr_control  = wr_access && (paddr == art_pkg::OFF_CONTROL);
    wr_request  = wr_access && (paddr == art_pkg::OFF_IRQ_REQ);
    wr_enable   = wr_access && (paddr == art_pkg::OFF_IRQ_EN);
    wr_priority = wr_access && (paddr == art_pkg::OFF_IRQ_PRIO);
    control_read = timer_control | art_pkg::CTRL_FIXED;
  end

  // ----------------------------------------------------------------
  // counter, reload and control
  // ----------------------------------------------------------------
  always_comb begin
    overflow = tick_bus.tick && timer_control[art_pkg::CTRL_RUN_BIT] &&
               (timer_count == art_pkg::COUNT_TOP);
    next_count   = timer_count;
    next_reload  = timer_reload;
    next_control = timer_control;
    if (tick_bus.tick && timer_control[art_pkg::CTRL_RUN_BIT]) begin
      if (overflow) begin
        next_count = timer_reload;
      end else begin
        next_count = timer_count + 8'h01;
      end
    end
    if (wr_count) begin
      next_count  = pwdata[7:0];
      next_reload = pwdata[7:0];
    end
    if (wr_reload) begin
      next_reload = pwdata[7:0];
    end
    if (wr_control) begin
      next_control = (pwdata[7:0] & ~art_pkg::CTRL_FIXED) |
                     (timer_control & art_pkg::CTRL_FIXED);
    end
    // a toggle in the write cycle inverts the written level, never lost
    if (overflow) begin
      next_control[art_pkg::CTRL_LEVEL_BIT] = ~next_control[art_pkg::CTRL_LEVEL_BIT];
    end
  end

  // count and reload carry no meaningful reset value, zero is only for determinism
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count   <= art_pkg::COUNT_RESET;
      timer_reload  <= art_pkg::RELOAD_RESET;
      timer_control <= art_pkg::CTRL_RESET;
    end else begin
      timer_count   <= next_count;
      timer_reload  <= next_reload;
      timer_control <= next_control;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags and outputs
  // ----------------------------------------------------------------
  always_comb begin
    next_request  = overflow_irq_request;
    next_enable   = overflow_irq_enable;
    next_priority = overflow_priority;
    if (wr_request && pwdata[0]) begin
      next_request = 1'b0;
    end
    if (overflow) begin
      next_request = 1'b1;
    end
    if (wr_enable) begin
      next_enable = pwdata[0];
    end
    if (wr_priority) begin
      next_priority = pwdata[1:0];
    end
    next_irq  = next_request && next_enable;
    next_baud = overflow;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_request <= 1'b0;
      overflow_irq_enable  <= 1'b0;
      overflow_priority    <= art_pkg::PRIO_RESET;
      overflow_irq         <= 1'b0;
      baud_tick            <= 1'b0;
      timer_out            <= art_pkg::CTRL_RESET[art_pkg::CTRL_LEVEL_BIT];
      irq_priority         <= art_pkg::PRIO_RESET;
      irq_vector           <= art_pkg::IRQ_VECTOR;
    end else begin
      overflow_irq_request <= next_request;
      overflow_irq_enable  <= next_enable;
      overflow_priority    <= next_priority;
      overflow_irq         <= next_irq;
      baud_tick            <= next_baud;
      timer_out            <= next_control[art_pkg::CTRL_LEVEL_BIT];
      irq_priority         <= next_priority;
      irq_vector           <= art_pkg::IRQ_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: data registered in setup, one access cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready  = 1'b1;
      next_pslverr = !mapped;
      next_prdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          art_pkg::OFF_COUNT:    next_prdata = {24'h00_0000, timer_count};
          art_pkg::OFF_RELOAD:   next_prdata = {24'h00_0000, timer_reload};
          art_pkg::OFF_CONTROL:  next_prdata = {24'h00_0000, control_read};
          art_pkg::OFF_IRQ_REQ:  next_prdata = {31'h0000_0000, overflow_irq_request};
          art_pkg::OFF_IRQ_EN:   next_prdata = {31'h0000_0000, overflow_irq_enable};
          art_pkg::OFF_IRQ_PRIO: next_prdata = {30'h0000_0000, overflow_priority};
          default:               next_prdata = 32'h0000_0000;
        endcase
      end
    end else if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ovf_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !wr_count |=> timer_count == $past(timer_reload))
    else $error("count not reloaded on overflow");

  count_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_count |=> (timer_count == $past(pwdata[7:0])) && (timer_reload == timer_count))
    else $error("count write did not copy into reload");

  reload_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_reload && !wr_count |=> timer_reload == $past(pwdata[7:0]))
    else $error("reload write lost");

  fixed_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_control[6:4] == 3'h7)
    else $error("control bits 4 to 6 not one");

  level_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !wr_control |=> timer_control[7] != $past(timer_control[7]))
    else $error("overflow did not invert level");

  pin_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_out == timer_control[7])
    else $error("output pin differs from level bit");

  halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_control[3] && !wr_count |=> $stable(timer_count))
    else $error("counter moved while halted");

  baud_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> baud_tick == $past(overflow))
    else $error("baud pulse does not follow overflow");

  irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> overflow_irq_request)
    else $error("overflow did not set request");

  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_irq == (overflow_irq_request && overflow_irq_enable))
    else $error("interrupt not gated by enable");

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_bus.tick && timer_control[3] && timer_count != 8'hFF && !wr_count
    |=> timer_count == $past(timer_count) + 8'h01)
    else $error("counter did not step by one");

  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_control |=> timer_control[3:0] == $past(pwdata[3:0]))
    else $error("control select or run bits not written");

  level_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_control && !overflow |=> timer_out == $past(pwdata[7]))
    else $error("written level not on output pin");

  irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_request && pwdata[0] && !overflow |=> !overflow_irq_request)
    else $error("request flag not cleared");

  irq_forward_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && overflow_irq_enable && !wr_enable |=> overflow_irq)
    else $error("enabled overflow not forwarded");

  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready && (pslverr == !$past(mapped)))
    else $error("access cycle not answered");

  ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

endmodule : art_timer
`default_nettype wire

// *** test/test_art_timer.sv ***
// Purpose: self-checking bench for the auto-reload timer with toggle output
// Assumes: APB slave answers with pready, bench drives on rising pclk edges
// Notes:   count clock codes 0 to 5 are measured, prohibited codes are not used
`timescale 1ns/1ps
`default_nettype none
module test_art_timer;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer_out;
  logic        baud_tick;
  logic        overflow_irq;
  logic [1:0]  irq_priority;
  logic [15:0] irq_vector;
  logic [31:0] rd;
  logic [31:0] held;
  logic        err;
  logic        lvl;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          gap;

  art_timer dut_u (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .timer_out    (timer_out),
    .baud_tick    (baud_tick),
    .overflow_irq (overflow_irq),
    .irq_priority (irq_priority),
    .irq_vector   (irq_vector)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", {31'h0, pready}, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wreg

  task automatic rreg(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rreg

  // waits for a baud pulse, then counts cycles up to the next one
  task automatic tick_gap(output int n);
    int k;
    k = 0;
    while (baud_tick !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
    check("baud width", {31'h0, baud_tick}, 32'h0);
    n = 1;
    while (baud_tick !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask : tick_gap

  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rreg("control reset", art_pkg::OFF_CONTROL, 32'h70);
    check("vector", {16'h0, irq_vector}, 32'h36);
    check("pin reset", {31'h0, timer_out}, 32'h0);
    wreg(art_pkg::OFF_CONTROL, 8'h85);
    rreg("control fixed", art_pkg::OFF_CONTROL, 32'hF5);
    check("pin level", {31'h0, timer_out}, 32'h1);
    wreg(art_pkg::OFF_CONTROL, 8'h00);
    rreg("control clear", art_pkg::OFF_CONTROL, 32'h70);
    wreg(art_pkg::OFF_COUNT, 8'hFE);
    rreg("count", art_pkg::OFF_COUNT, 32'hFE);
    rreg("reload copy", art_pkg::OFF_RELOAD, 32'hFE);
    wreg(art_pkg::OFF_RELOAD, 8'hF0);
    rreg("reload", art_pkg::OFF_RELOAD, 32'hF0);
    rreg("count kept", art_pkg::OFF_COUNT, 32'hFE);
    for (int p = 0; p < 4; p++) begin
      wreg(art_pkg::OFF_IRQ_PRIO, p[7:0]);
      rreg("prio reg", art_pkg::OFF_IRQ_PRIO, p);
      check("prio pin", {30'h0, irq_priority}, p);
    end
    wreg(art_pkg::OFF_IRQ_EN, 8'h01);
    // period is 16 count pulses of 2**code cycles each
    for (int s = 0; s < 6; s++) begin
      wreg(art_pkg::OFF_CONTROL, 8'h08 | s[7:0]);
      tick_gap(gap);
      lvl = timer_out;
      tick_gap(gap);
      check("period", gap, 16 << s);
      check("toggle", {31'h0, timer_out}, {31'h0, ~lvl});
    end
    check("irq out", {31'h0, overflow_irq}, 32'h1);
    rreg("irq flag", art_pkg::OFF_IRQ_REQ, 32'h1);
    wreg(art_pkg::OFF_IRQ_EN, 8'h00);
    check("irq masked", {31'h0, overflow_irq}, 32'h0);
    wreg(art_pkg::OFF_CONTROL, 8'h00);
    wreg(art_pkg::OFF_IRQ_REQ, 8'h01);
    rreg("irq cleared", art_pkg::OFF_IRQ_REQ, 32'h0);
    wreg(art_pkg::OFF_IRQ_EN, 8'h01);
    check("irq idle", {31'h0, overflow_irq}, 32'h0);
    apb(1'b0, art_pkg::OFF_COUNT, 32'h0);
    held = rd;
    repeat (600) @(posedge pclk);
    rreg("halted", art_pkg::OFF_COUNT, held);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    wrap_up();
  end
endmodule : test_art_timer
`default_nettype wire
